/* File: hdl/uart_consts.vh */
`ifndef UART_TX_RX_CONSTS_VH
`define UART_TX_RX_CONSTS_VH
// register byte offsets
`define OFS_MODE 5'h00
`define OFS_STAT 5'h04
`define OFS_TXD 5'h08
`define OFS_RXD 5'h0c
`define OFS_BRG 5'h10
// port_mode_register fields
`define MODE_EN 0
`define MODE_FMT_LO 1
`define MODE_FMT_HI 2
`define MODE_STOP2 3
`define MODE_HS_LO 8
`define MODE_HS_HI 9
// status/control register fields
`define STAT_TXISEL_LO 0
`define STAT_TXISEL_HI 1
`define STAT_RXISEL_LO 2
`define STAT_RXISEL_HI 3
`define STAT_TXEN 4
`define STAT_BRK 5
`define STAT_OVR 6
`define STAT_RXAV 7
`define STAT_TXFULL 8
`define STAT_TRMT 9
`define STAT_PARITY_ERROR_FLAG 10
`define STAT_FRAMING_ERROR_FLAG 11
// character formats
`define FMT_8N 2'h0
`define FMT_8E 2'h1
`define FMT_8O 2'h2
`define FMT_9N 2'h3
// handshake pin configurations
`define HS_NONE 2'h0
`define HS_SIMPLEX 2'h1
`define HS_FLOW 2'h2
`define HS_BCLK 2'h3
// tx interrupt select
`define TXI_LOAD 2'h0
`define TXI_DONE 2'h1
`define TXI_EMPTY 2'h2
// rx interrupt select
`define RXI_THREEQ 2'h2
`define RXI_FULL 2'h3
`define RX_THREEQ_LVL 4'h6
// timing
`define MID_TICK 4'h7
`define LAST_TICK 4'hf
`define BRK_BITS 4'he
`define FIFO_DEPTH 8
`define FIFO_AW 3
// reset values and bus answers
`define BRG_RST 16'h0000
`define MODE_RST 10'h000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: hdl/uart_tx_rx_sequencing.v */
// Functional notes
// (R1) Software sets format and baud divisor, then interrupt setup, before enabling.
// (R2) Setting tx enable pulses the tx interrupt two cycles later.
// (R3) 8-bit low-byte write moves to shift register; shifting starts next baud edge.
// (R4) Byte loaded while disabled starts at once on enable, baud count cleared.
// (R5) Tx interrupt condition follows the tx interrupt select field.
// (R6) 9-bit mode accepts only full word writes; all nine bits are sent.
// (R7) With send-break set, the next written character is ignored and starts a break.
// (R8) Sync 55h written after the dummy waits in the tx FIFO behind the break.
// (R9) After the break is sent, hardware clears send-break, then sends the queued sync.
// (R10) Rx interrupt on received characters, condition from rx interrupt select.
// (R11) Overrun flag is sticky; only software clears it.
// (R12) Reading rx data pops the FIFO, showing the next character's own error flags.
// (R13) CTS/RTS pins support simplex and flow control per handshake config field.
// (R14) Handshake config 11 with port enabled drives a 16x baud clock on RTS for a nonzero divisor.
// (R15) Frame: low start, data LSB first, optional parity, high stops, idle high.
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "uart_consts.vh"

module uart_fifo #(
  parameter W = 9,
  parameter D = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire nrst,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data,
  output reg [AW:0] count_ff
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wptr_ff;
  reg [AW-1:0] rptr_ff;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = (count_ff != D[AW:0]);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign out_data = mem[rptr_ff];
  always @(posedge clk) begin
    if (push) begin
      mem[wptr_ff] <= in_data;
    end
  end
  always @(posedge clk) begin
    if (!nrst) begin
      wptr_ff <= {AW{1'b0}};
      rptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr_ff <= wptr_ff + 1'b1;
      end
      if (pop) begin
        rptr_ff <= rptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule // uart_fifo

////////////////////////////////////////////////////////////////////////////////

module uart_tx_rx_sequencing (
  input wire CLK,
  input wire NRST,
  input wire AWVALID,
  output wire AWREADY,
  input wire [7:0] AWADDR,
  input wire WVALID,
  output wire WREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  output reg BVALID,
  input wire BREADY,
  output reg [1:0] BRESP,
  input wire ARVALID,
  output wire ARREADY,
  input wire [7:0] ARADDR,
  output reg RVALID,
  input wire RREADY,
  output reg [31:0] RDATA,
  output reg [1:0] RRESP,
  input wire RX,
  output reg TX,
  input wire CLEAR_TO_SEND_PIN_N,
  output reg REQUEST_TO_SEND_PIN_N,
  output reg TX_IRQ,
  output reg RX_IRQ
);
  localparam TX_IDLE = 2'h0;
  localparam TX_WAIT = 2'h1;
  localparam TX_SHIFT = 2'h2;
  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_BITS = 2'h2;

  // data plus parity bit count for a format
  function [3:0] frame_bits;
    input [1:0] fmt;
    begin
      frame_bits = (fmt == `FMT_8N) ? 4'h8 : 4'h9;
    end
  endfunction

  function par_bit;
    input [1:0] fmt;
    input [8:0] d;
    begin
      par_bit = (^d[7:0]) ^ (fmt == `FMT_8O);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg [9:0] mode_ff;
  reg [15:0] brg_ff;
  reg [1:0] txisel_ff;
  reg [1:0] rxisel_ff;
  reg txen_ff;
  reg brk_ff;
  reg ovr_ff;
  reg aw_ff;
  reg w_ff;
  reg [4:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  wire port_en = mode_ff[`MODE_EN];
  wire [1:0] fmt = mode_ff[`MODE_FMT_HI:`MODE_FMT_LO];
  wire [1:0] hs = mode_ff[`MODE_HS_HI:`MODE_HS_LO];

  wire tx_in_ready;
  wire tx_out_valid;
  wire [8:0] tx_out_data;
  wire rx_in_ready;
  wire rx_out_valid;
  wire [10:0] rx_out_data;
  wire [3:0] rx_count;
  reg rx_push;
  reg [10:0] rx_word;
  wire brk_done;

  assign AWREADY = !aw_ff;
  assign WREADY = !w_ff;
  assign ARREADY = !RVALID;
  wire wr_txd = (awaddr_ff == `OFS_TXD);
  // a tx write waits for FIFO room, so bus back-pressure reaches software
  wire do_wr = aw_ff & w_ff & !BVALID & !(wr_txd & !tx_in_ready);
  wire wr_word = (wstrb_ff[1:0] == 2'h3);
  wire tx_push = do_wr & wr_txd & port_en &
    ((fmt == `FMT_9N) ? wr_word : wstrb_ff[0]); // (R3) (R6)
  wire wr_stat = do_wr & (awaddr_ff == `OFS_STAT) & wstrb_ff[0];
  wire rd_take = ARVALID & !RVALID;
  wire rd_pop = rd_take & (ARADDR[4:0] == `OFS_RXD) & rx_out_valid;
  wire ovr_set = rx_push & !rx_in_ready;

  always @(posedge CLK) begin
    if (!NRST) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 5'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= `RESP_OKAY;
      mode_ff <= `MODE_RST;
      brg_ff <= `BRG_RST;
      txisel_ff <= 2'h0;
      rxisel_ff <= 2'h0;
      txen_ff <= 1'b0;
      brk_ff <= 1'b0;
      ovr_ff <= 1'b0;
    end else begin
      if (AWVALID && !aw_ff) begin
        aw_ff <= 1'b1;
        awaddr_ff <= AWADDR[4:0];
      end
      if (WVALID && !w_ff) begin
        w_ff <= 1'b1;
        wdata_ff <= WDATA;
        wstrb_ff <= WSTRB;
      end
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
      if (do_wr) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= `RESP_OKAY;
        case (awaddr_ff)
          `OFS_MODE: begin
            if (wstrb_ff[0]) mode_ff[7:0] <= wdata_ff[7:0];
            if (wstrb_ff[1]) mode_ff[9:8] <= wdata_ff[9:8];
          end
          `OFS_BRG: begin
            if (wstrb_ff[0]) brg_ff[7:0] <= wdata_ff[7:0];
            if (wstrb_ff[1]) brg_ff[15:8] <= wdata_ff[15:8];
          end
          `OFS_STAT, `OFS_TXD: begin
          end
          default: begin
            BRESP <= `RESP_SLVERR;
          end
        endcase
      end
      if (wr_stat) begin
        txisel_ff <= wdata_ff[`STAT_TXISEL_HI:`STAT_TXISEL_LO];
        rxisel_ff <= wdata_ff[`STAT_RXISEL_HI:`STAT_RXISEL_LO];
        txen_ff <= wdata_ff[`STAT_TXEN];
      end
      // hardware clear after the break; a software set in the same cycle wins
      if (wr_stat && wdata_ff[`STAT_BRK]) begin
        brk_ff <= 1'b1;
      end else if (brk_done || (wr_stat && !wdata_ff[`STAT_BRK])) begin
        brk_ff <= 1'b0; // (R9)
      end
      // only a software write of zero clears; a new overrun wins
      if (ovr_set) begin
        ovr_ff <= 1'b1; // (R11)
      end else if (wr_stat && !wdata_ff[`STAT_OVR]) begin
        ovr_ff <= 1'b0; // (R11)
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel
  wire tx_busy;
  reg [31:0] rd_val;
  reg [1:0] rd_resp;
  always @* begin
    rd_val = 32'h00000000;
    rd_resp = `RESP_OKAY;
    case (ARADDR[4:0])
      `OFS_MODE: rd_val[9:0] = mode_ff;
      `OFS_BRG: rd_val[15:0] = brg_ff;
      `OFS_STAT: begin
        rd_val[`STAT_TXISEL_HI:`STAT_TXISEL_LO] = txisel_ff;
        rd_val[`STAT_RXISEL_HI:`STAT_RXISEL_LO] = rxisel_ff;
        rd_val[`STAT_TXEN] = txen_ff;
        rd_val[`STAT_BRK] = brk_ff;
        rd_val[`STAT_OVR] = ovr_ff;
        rd_val[`STAT_RXAV] = rx_out_valid;
        rd_val[`STAT_TXFULL] = !tx_in_ready;
        rd_val[`STAT_TRMT] = !tx_busy & !tx_out_valid;
        rd_val[`STAT_PARITY_ERROR_FLAG] = rx_out_valid & rx_out_data[9];
        rd_val[`STAT_FRAMING_ERROR_FLAG] = rx_out_valid & rx_out_data[10];
      end
      `OFS_RXD: rd_val[8:0] = rx_out_valid ? rx_out_data[8:0] : 9'h000;
      `OFS_TXD: rd_val = 32'h00000000;
      default: rd_resp = `RESP_SLVERR;
    endcase
  end

  always @(posedge CLK) begin
    if (!NRST) begin
      RVALID <= 1'b0;
      RDATA <= 32'h00000000;
      RRESP <= `RESP_OKAY;
    end else if (rd_take) begin
      RVALID <= 1'b1;
      RDATA <= rd_val;
      RRESP <= rd_resp;
    end else if (RREADY) begin
      RVALID <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // baud generator: x16 tick, held cleared while the port is off
  reg [15:0] bcnt_ff;
  reg bclk_ff;
  wire tick = port_en & (bcnt_ff == brg_ff);
  wire half = port_en & (bcnt_ff == {1'b0, brg_ff[15:1]});
  always @(posedge CLK) begin
    if (!NRST || !port_en) begin
      bcnt_ff <= 16'h0000;
      bclk_ff <= 1'b0;
    end else begin
      bcnt_ff <= tick ? 16'h0000 : bcnt_ff + 16'h0001;
      // a zero divisor toggles every cycle, at half the tick rate; duty is coarse for even divisors
      if (tick || half) bclk_ff <= ~bclk_ff; // (R14)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmitter
  reg [1:0] txs_ff;
  reg [12:0] tsh_ff;
  reg [3:0] tleft_ff;
  reg [3:0] tsub_ff;
  reg tbrk_ff;
  reg cts_s1_ff;
  reg cts_s2_ff;
  wire cts_ok = (hs != `HS_FLOW) | !cts_s2_ff; // (R13)
  wire tx_pop = (txs_ff == TX_IDLE) & txen_ff & port_en & tx_out_valid & cts_ok;
  wire tbit_end = (txs_ff == TX_SHIFT) & tick & (tsub_ff == `LAST_TICK);
  wire tx_last = tbit_end & (tleft_ff == 4'h1);
  assign tx_busy = (txs_ff != TX_IDLE);
  assign brk_done = tx_last & tbrk_ff;

  uart_fifo #(.W(9), .D(`FIFO_DEPTH), .AW(`FIFO_AW)) tx_fifo (
    .clk(CLK),
    .nrst(NRST),
    .in_valid(tx_push),
    .in_ready(tx_in_ready),
    .in_data((fmt == `FMT_9N) ? wdata_ff[8:0] : {1'b0, wdata_ff[7:0]}),
    .out_valid(tx_out_valid),
    .out_ready(tx_pop),
    .out_data(tx_out_data),
    .count_ff()
  ); // (R8)

  always @(posedge CLK) begin
    if (!NRST) begin
      cts_s1_ff <= 1'b1;
      cts_s2_ff <= 1'b1;
      txs_ff <= TX_IDLE;
      tsh_ff <= 13'h1fff;
      tleft_ff <= 4'h0;
      tsub_ff <= 4'h0;
      tbrk_ff <= 1'b0;
      TX <= 1'b1;
    end else begin
      cts_s1_ff <= CLEAR_TO_SEND_PIN_N;
      cts_s2_ff <= cts_s1_ff;
      case (txs_ff)
        TX_IDLE: begin
          TX <= 1'b1; // (R15)
          tsub_ff <= 4'h0; // (R4)
          if (tx_pop) begin
            txs_ff <= TX_WAIT; // (R3)
            tbrk_ff <= brk_ff; // (R7)
            if (brk_ff) begin
              tsh_ff <= 13'h0000; // (R7)
              tleft_ff <= `BRK_BITS;
            end else begin
              // start, data lsb first, parity, stops; ones shift in behind
              if (fmt == `FMT_9N) begin
                tsh_ff <= {3'h7, tx_out_data, 1'b0}; // (R6) (R15)
              end else if (fmt == `FMT_8N) begin
                tsh_ff <= {4'hf, tx_out_data[7:0], 1'b0}; // (R15)
              end else begin
                tsh_ff <= {3'h7, par_bit(fmt, tx_out_data), tx_out_data[7:0], 1'b0};
              end
              tleft_ff <= frame_bits(fmt) + 4'h2 + {3'h0, mode_ff[`MODE_STOP2]};
            end
          end
        end
        TX_WAIT: begin
          if (tick) begin
            txs_ff <= TX_SHIFT; // (R3) (R4)
            TX <= tsh_ff[0];
            tsh_ff <= {1'b1, tsh_ff[12:1]};
          end
        end
        TX_SHIFT: begin
          if (tick) tsub_ff <= tsub_ff + 4'h1;
          if (tx_last) begin
            txs_ff <= TX_IDLE;
            tbrk_ff <= 1'b0;
            TX <= 1'b1;
          end else if (tbit_end) begin
            tleft_ff <= tleft_ff - 4'h1;
            TX <= tsh_ff[0];
            tsh_ff <= {1'b1, tsh_ff[12:1]};
          end
        end
        default: txs_ff <= TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tx interrupt
  reg txen_dly_ff;
  reg txen_prev_ff;
  reg tx_empty_prev_ff;
  reg tx_cond;
  always @* begin
    case (txisel_ff)
      `TXI_DONE: tx_cond = tx_last & !tx_out_valid;
      `TXI_EMPTY: tx_cond = tx_out_valid == 1'b0 && tx_empty_prev_ff == 1'b0;
      default: tx_cond = tx_pop;
    endcase
  end
  always @(posedge CLK) begin
    if (!NRST) begin
      txen_prev_ff <= 1'b0;
      txen_dly_ff <= 1'b0;
      tx_empty_prev_ff <= 1'b1;
      TX_IRQ <= 1'b0;
    end else begin
      txen_prev_ff <= txen_ff;
      txen_dly_ff <= txen_ff & !txen_prev_ff;
      tx_empty_prev_ff <= !tx_out_valid;
      TX_IRQ <= txen_dly_ff | (txen_ff & tx_cond); // (R2) (R5)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver
  reg rx_s1_ff;
  reg rx_s2_ff;
  reg [1:0] rxs_ff;
  reg [3:0] rsub_ff;
  reg [3:0] ridx_ff;
  reg [9:0] rsh_ff;
  wire [3:0] rlast = frame_bits(fmt);
  wire [8:0] rdat = (fmt == `FMT_9N) ? rsh_ff[8:0] : {1'b0, rsh_ff[7:0]};
  wire rperr = (fmt == `FMT_8E || fmt == `FMT_8O) && (rsh_ff[8] != par_bit(fmt, rdat));

  uart_fifo #(.W(11), .D(`FIFO_DEPTH), .AW(`FIFO_AW)) rx_fifo (
    .clk(CLK),
    .nrst(NRST),
    .in_valid(rx_push),
    .in_ready(rx_in_ready),
    .in_data(rx_word),
    .out_valid(rx_out_valid),
    .out_ready(rd_pop),
    .out_data(rx_out_data),
    .count_ff(rx_count)
  ); // (R12)

  always @(posedge CLK) begin
    if (!NRST) begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
      rxs_ff <= RX_IDLE;
      rsub_ff <= 4'h0;
      ridx_ff <= 4'h0;
      rsh_ff <= 10'h000;
      rx_push <= 1'b0;
      rx_word <= 11'h000;
    end else begin
      rx_s1_ff <= RX;
      rx_s2_ff <= rx_s1_ff;
      rx_push <= 1'b0;
      case (rxs_ff)
        RX_IDLE: begin
          rsub_ff <= 4'h0;
          ridx_ff <= 4'h0;
          if (port_en && tick && !rx_s2_ff) rxs_ff <= RX_START; // (R15)
        end
        RX_START: begin
          if (tick) begin
            rsub_ff <= rsub_ff + 4'h1;
            // a glitch shorter than half a bit is not a start
            if (rsub_ff == `MID_TICK) begin
              rsub_ff <= 4'h0;
              rxs_ff <= rx_s2_ff ? RX_IDLE : RX_BITS;
            end
          end
        end
        RX_BITS: begin
          if (tick) begin
            rsub_ff <= rsub_ff + 4'h1;
            if (rsub_ff == `LAST_TICK) begin
              if (ridx_ff == rlast) begin
                rxs_ff <= RX_IDLE;
                rx_push <= 1'b1;
                rx_word <= {!rx_s2_ff, rperr, rdat}; // (R12) (R15)
              end else begin
                rsh_ff[ridx_ff] <= rx_s2_ff;
                ridx_ff <= ridx_ff + 4'h1;
              end
            end
          end
        end
        default: rxs_ff <= RX_IDLE;
      endcase
      if (!port_en) rxs_ff <= RX_IDLE;
    end
  end

  reg rx_cond;
  always @* begin
    case (rxisel_ff)
      `RXI_THREEQ: rx_cond = (rx_count == (`RX_THREEQ_LVL - 4'h1));
      `RXI_FULL: rx_cond = (rx_count == (`FIFO_DEPTH - 1));
      default: rx_cond = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // rx interrupt and handshake pins
  always @(posedge CLK) begin
    if (!NRST) begin
      RX_IRQ <= 1'b0;
      REQUEST_TO_SEND_PIN_N <= 1'b1;
    end else begin
      RX_IRQ <= rx_push & rx_in_ready & rx_cond; // (R10)
      case (hs)
        `HS_SIMPLEX: REQUEST_TO_SEND_PIN_N <= !(tx_busy | tx_out_valid); // (R13)
        `HS_FLOW: REQUEST_TO_SEND_PIN_N <= !rx_in_ready; // (R13)
        `HS_BCLK: REQUEST_TO_SEND_PIN_N <= port_en ? bclk_ff : 1'b1; // (R14)
        default: REQUEST_TO_SEND_PIN_N <= 1'b1;
      endcase
    end
  end
endmodule // uart_tx_rx_sequencing

/* File: tb/uart_line_partner.sv */
`timescale 1ns/1ps
// far-side serial node: samples mid-bit at 16 cycles a bit (divisor 0)
module uart_line_partner (
  input wire clk,
  input wire line_in,
  output logic line_out
);
  int nb = 8;
  logic [9:0] got[$];
  logic [8:0] sh;
  logic st;
  initial line_out = 1'b1;
  ////////////////////////////////////////////////////////////////////////////////
  always begin
    @(negedge line_in);
    repeat (8) @(posedge clk);
    sh = '0;
    for (int i = 0; i <= nb; i++) begin
      repeat (16) @(posedge clk);
      if (i < nb) sh[i] = line_in;
      else st = line_in;
    end
    got.push_back({st, sh});
    // a break holds the line low past the stop slot
    if (!st) wait (line_in);
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic put(input logic b);
    @(posedge clk);
    line_out <= b;
    repeat (15) @(posedge clk);
  endtask
  task automatic send(input logic [8:0] d, input int n, input logic stp);
    put(1'b0);
    for (int i = 0; i < n; i++) put(d[i]);
    put(stp);
    put(1'b1);
  endtask
endmodule // uart_line_partner

/* File: tb/uart_tx_rx_sequencing_monitor.sv */
`timescale 1ns/1ps
`include "uart_consts.vh"
module uart_tx_rx_sequencing_monitor (
  input wire CLK,
  input wire NRST,
  input wire AWVALID,
  input wire AWREADY,
  input wire [7:0] AWADDR,
  input wire WVALID,
  input wire WREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire BVALID,
  input wire BREADY,
  input wire [1:0] BRESP,
  input wire ARVALID,
  input wire ARREADY,
  input wire RVALID,
  input wire RREADY,
  input wire [31:0] RDATA,
  input wire TX,
  input wire TX_IRQ,
  input wire RX_IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  ////////////////////////////////////////////////////////////////////////////////
  // shadow of tx enable, so only a 0 to 1 write arms the irq check
  reg txen_ff;
  wire wr_go = AWVALID && AWREADY && WVALID && WREADY;
  wire stat_wr = wr_go && AWADDR[4:0] == `OFS_STAT && WSTRB[0];
  wire nxt_txen = stat_wr ? WDATA[`STAT_TXEN] : txen_ff;
  always @(posedge CLK) begin
    if (!NRST) begin
      txen_ff <= 1'b0;
    end else begin
      txen_ff <= nxt_txen;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_start; $fell(TX); endsequence
  sequence s_low; !TX [*7]; endsequence
  sequence s_ar_take; ARVALID && ARREADY; endsequence
  sequence s_r_ans; RVALID && !ARREADY; endsequence
  property p_start_bit; s_start |=> s_low; endproperty
  property p_high_bit; $rose(TX) |=> TX [*7]; endproperty
  // taken at the handshake, bit set one edge later, irq two cycles after that
  property p_txen_irq; stat_wr && WDATA[`STAT_TXEN] && !txen_ff |-> ##4 TX_IRQ; endproperty
  property p_rx_pulse; RX_IRQ |=> !RX_IRQ; endproperty
  property p_b_hold; BVALID && !BREADY |=> BVALID && $stable(BRESP); endproperty
  property p_r_hold; RVALID && !RREADY |=> RVALID && $stable(RDATA); endproperty
  property p_ar_turn; s_ar_take |=> s_r_ans; endproperty
  property p_wr_ans; wr_go && AWADDR[4:0] != `OFS_TXD |-> ##2 BVALID; endproperty
  property p_slverr; wr_go && AWADDR[4:0] == 5'h14 |-> ##2 BRESP == `RESP_SLVERR; endproperty
  property p_rst_idle; $rose(NRST) |-> TX && !BVALID && !RVALID; endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit too short");
  a_high_bit: assert property (p_high_bit) else $error("high bit too short");
  a_txen_irq: assert property (p_txen_irq) else $error("no tx irq after enable");
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx irq not a pulse");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  a_ar_turn: assert property (p_ar_turn) else $error("read answer late");
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  a_slverr: assert property (p_slverr) else $error("unmapped write not refused");
  a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
endmodule // uart_tx_rx_sequencing_monitor

bind uart_tx_rx_sequencing uart_tx_rx_sequencing_monitor uart_tx_rx_sequencing_monitor_i (
  .CLK, .NRST, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY, .WDATA, .WSTRB,
  .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .RVALID, .RREADY, .RDATA,
  .TX, .TX_IRQ, .RX_IRQ);

/* File: tb/uart_tx_rx_sequencing_tb.sv */
`timescale 1ns/1ps
`include "uart_consts.vh"
module uart_tx_rx_sequencing_tb;
  logic CLK = 1'b0, NRST = 1'b0, CTS_N = 1'b0;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic [7:0] AWADDR = '0, ARADDR = '0;
  logic [31:0] WDATA = '0, v;
  logic [3:0] WSTRB = '0;
  wire AWREADY, WREADY, BVALID, ARREADY, RVALID, TX, RX, RTS_N, TX_IRQ, RX_IRQ;
  wire [1:0] BRESP, RRESP;
  wire [31:0] RDATA;
  int bad_count = 0, n_checks = 0, cyc = 0, ntx = 0, nrx = 0, k, seed = 40919;
  logic [1:0] r;
  logic [9:0] e;
  logic [8:0] d;
  logic [9:0] exq[$];
  logic [8:0] rxq[$];
  initial forever #2 CLK = ~CLK;
  uart_tx_rx_sequencing uart_tx_rx_sequencing_i (
    .CLK, .NRST, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY, .WDATA, .WSTRB,
    .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR, .RVALID, .RREADY,
    .RDATA, .RRESP, .RX, .TX, .CLEAR_TO_SEND_PIN_N(CTS_N),
    .REQUEST_TO_SEND_PIN_N(RTS_N), .TX_IRQ, .RX_IRQ);
  uart_line_partner uart_line_partner_i (.clk(CLK), .line_in(TX), .line_out(RX));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ceiling far above the ~6k cycles the tests need
  always @(posedge CLK) begin
    cyc++;
    if (TX_IRQ === 1'b1) ntx++;
    if (RX_IRQ === 1'b1) nrx++;
    if (cyc == 30000) begin
      bad_count++;
      results();
    end
  end
  task automatic chk(input string n, input [31:0] ex, input [31:0] g);
    n_checks++;
    if (g !== ex) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, ex, g);
    end
  endtask
  task automatic wr(input [7:0] a, input [31:0] dt, input [3:0] s, input [1:0] er);
    @(posedge CLK);
    AWVALID <= 1'b1;
    AWADDR <= a;
    WVALID <= 1'b1;
    WDATA <= dt;
    WSTRB <= s;
    BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (AWVALID && !AWREADY || WVALID && !WREADY);
    while (BVALID !== 1'b1) @(posedge CLK);
    chk("bresp", er, BRESP);
    BREADY <= 1'b0;
  endtask
  task automatic rd(input [7:0] a);
    @(posedge CLK);
    ARVALID <= 1'b1;
    ARADDR <= a;
    RREADY <= 1'b1;
    do @(posedge CLK); while (ARREADY !== 1'b1);
    ARVALID <= 1'b0;
    do @(posedge CLK); while (RVALID !== 1'b1);
    v = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
  endtask
  task automatic rdc(input [7:0] a, input [31:0] ex, input [31:0] m);
    rd(a);
    chk("read data", ex, v & m);
  endtask
  // line model: {stop, parity or ninth bit, data}
  function automatic logic [9:0] mk(input int f, input logic [8:0] x);
    logic p;
    p = f == 3 ? x[8] : f == 1 ? ^x[7:0] : f == 2 ? ~^x[7:0] : 1'b0;
    mk = {1'b1, p, x[7:0]};
  endfunction
  task automatic take_line(input int n);
    while (uart_line_partner_i.got.size() < n) @(posedge CLK);
    repeat (n) chk("line char", exq.pop_front(), uart_line_partner_i.got.pop_front());
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge CLK);
    NRST <= 1'b1;
    rdc(`OFS_MODE, `MODE_RST, 32'h3ff);
    rdc(`OFS_BRG, `BRG_RST, 32'hffff);
    rdc(`OFS_STAT, 32'h200, 32'hfff);
    rdc(`OFS_TXD, 32'h0, 32'hffffffff);
    rdc(8'h14, 32'h0, 32'hffffffff);
    chk("rresp", `RESP_SLVERR, r);
    wr(8'h14, 32'h1, 4'hf, `RESP_SLVERR);
    wr(`OFS_BRG, 32'h0, 4'h3, `RESP_OKAY);
    wr(`OFS_MODE, 32'h1, 4'h3, `RESP_OKAY);
    d = 9'($random(seed));
    wr(`OFS_TXD, d, 4'h1, `RESP_OKAY);
    exq.push_back(mk(0, d));
    chk("tx idle", 32'h1, TX);
    wr(`OFS_STAT, 32'h10, 4'h1, `RESP_OKAY);
    take_line(1);
    $display("test preload done");
    for (int f = 0; f < 4; f++) begin
      uart_line_partner_i.nb = f ? 9 : 8;
      wr(`OFS_MODE, {f[1:0], 1'b1}, 4'h1, `RESP_OKAY);
      wr(`OFS_STAT, 32'h10 | f % 3, 4'h1, `RESP_OKAY);
      k = ntx;
      if (f == 3) wr(`OFS_TXD, 32'h1ff, 4'h1, `RESP_OKAY);
      repeat (2) begin
        d = 9'($random(seed));
        wr(`OFS_TXD, d, f == 3 ? 4'h3 : 4'h1, `RESP_OKAY);
        exq.push_back(mk(f, d));
      end
      take_line(2);
      for (int i = 0; i < 64 && ntx == k; i++) @(posedge CLK);
      chk("tx irq", 32'h1, ntx > k);
      d = 9'($random(seed));
      e = mk(f, d) ^ (f == 1 ? 10'h100 : 10'h000);
      k = nrx;
      uart_line_partner_i.send(e[8:0], f ? 9 : 8, 1'b1);
      while (nrx == k) @(posedge CLK);
      chk("rx irq", k + 1, nrx);
      rdc(`OFS_STAT, {f == 1, 10'h0}, 32'h400);
      rdc(`OFS_RXD, f == 3 ? d : d & 9'h0ff, f == 3 ? 32'h1ff : 32'hff);
      $display("test format %0d done", f);
    end
    uart_line_partner_i.nb = 8;
    wr(`OFS_MODE, 32'h1, 4'h1, `RESP_OKAY);
    wr(`OFS_STAT, 32'h30, 4'h1, `RESP_OKAY);
    wr(`OFS_TXD, $random(seed), 4'h1, `RESP_OKAY);
    wr(`OFS_TXD, 32'h55, 4'h1, `RESP_OKAY);
    exq.push_back(10'h000);
    exq.push_back(mk(0, 9'h055));
    take_line(2);
    rdc(`OFS_STAT, 32'h0, 32'h20);
    $display("test break done");
    wr(`OFS_STAT, 32'h1c, 4'h1, `RESP_OKAY);
    k = nrx;
    for (int i = 0; i < 9; i++) begin
      d = 9'($random(seed));
      uart_line_partner_i.send(d, 8, i != 2);
      if (rxq.size() < 8) rxq.push_back({i == 2, d[7:0]});
    end
    chk("rx irq full", 32'h1, nrx > k);
    rdc(`OFS_STAT, 32'h40, 32'h40);
    wr(`OFS_STAT, 32'h5c, 4'h1, `RESP_OKAY);
    rdc(`OFS_STAT, 32'h40, 32'h40);
    while (rxq.size()) begin
      e = rxq.pop_front();
      rdc(`OFS_STAT, {e[8], 11'h0}, 32'h800);
      rdc(`OFS_RXD, e[7:0], 32'hff);
    end
    rdc(`OFS_STAT, 32'h40, 32'hc0);
    wr(`OFS_STAT, 32'h1c, 4'h1, `RESP_OKAY);
    rdc(`OFS_STAT, 32'h0, 32'h40);
    $display("test overrun done");
    CTS_N <= 1'b1;
    wr(`OFS_MODE, 32'h201, 4'h3, `RESP_OKAY);
    wr(`OFS_TXD, 32'h0a5, 4'h1, `RESP_OKAY);
    exq.push_back(mk(0, 9'h0a5));
    repeat (200) @(posedge CLK);
    chk("held by cts", 32'h0, uart_line_partner_i.got.size());
    chk("rts room", 32'h0, RTS_N);
    CTS_N <= 1'b0;
    take_line(1);
    wr(`OFS_MODE, 32'h101, 4'h3, `RESP_OKAY);
    wr(`OFS_TXD, 32'h03c, 4'h1, `RESP_OKAY);
    exq.push_back(mk(0, 9'h03c));
    repeat (2) @(posedge CLK);
    chk("rts simplex busy", 32'h0, RTS_N);
    take_line(1);
    repeat (16) @(posedge CLK);
    chk("rts simplex idle", 32'h1, RTS_N);
    wr(`OFS_MODE, 32'h0, 4'h3, `RESP_OKAY);
    wr(`OFS_BRG, 32'h3, 4'h3, `RESP_OKAY);
    wr(`OFS_MODE, 32'h301, 4'h3, `RESP_OKAY);
    k = 0;
    e[1] = RTS_N;
    repeat (64) begin
      @(posedge CLK);
      if (RTS_N && !e[1]) k++;
      e[1] = RTS_N;
    end
    chk("x16 clock rises", 32'd16, k);
    $display("test handshake done");
    results();
  end
endmodule // uart_tx_rx_sequencing_tb
